// ==== hw/ics_pkg.sv ====
package ics_pkg;

  // ---------------------------------------------------------------------------
  // header and opcodes
  // ---------------------------------------------------------------------------
  localparam logic [6:0] ICS_DEV_ADDR = 7'h60;
  localparam logic [7:0] OP_RAM_WR = 8'h00;
  localparam logic [7:0] OP_RAM_RD = 8'h40;
  localparam logic [7:0] OP_PWR_RST = 8'hF0;
  localparam logic [7:0] OP_INIT_RST = 8'hC0;
  localparam logic [7:0] OP_CONT_GO = 8'hCC;
  localparam logic [7:0] OP_ONE_GO = 8'hCE;
  localparam logic [7:0] OP_WD_OFF = 8'h9E;
  localparam logic [7:0] OP_WD_ON = 8'h9F;
  localparam logic [7:0] OP_EE_RD = 8'hA0;
  localparam logic [7:0] OP_EE_WR = 8'hA1;
  localparam logic [7:0] OP_EE_ERASE = 8'hA2;
  localparam logic [7:0] OP_EE_BERASE = 8'hA4;
  localparam logic [7:0] OP_BGAP_OFF = 8'h86;
  localparam logic [7:0] OP_BGAP_ON = 8'h87;
  localparam logic [7:0] OP_EEACC_OFF = 8'h90;
  localparam logic [7:0] OP_EEACC_ON = 8'h91;
  localparam logic [7:0] OP_OTP_RD = 8'hA6;
  localparam logic [7:0] OP_OTP_WR = 8'hA7;
  localparam logic [7:0] OP_OTP_EN_OFF = 8'hA8;
  localparam logic [7:0] OP_OTP_EN_ON = 8'hA9;
  localparam logic [7:0] OP_PROG_OFF = 8'hAC;
  localparam logic [7:0] OP_PROG_ON = 8'hAD;
  localparam logic [7:0] OP_XEE_RD = 8'h50;
  localparam logic [7:0] OP_XEE_WR = 8'h52;
  localparam logic [7:0] OP_XEE_SEL = 8'h53;
  localparam logic [7:0] ICS_FILL = 8'h00;
  localparam logic [7:0] ICS_ERASED = 8'h00;

  // ---------------------------------------------------------------------------
  // level and pulse bit positions, frame byte slots
  // ---------------------------------------------------------------------------
  localparam int LV_WD = 0;
  localparam int LV_BGAP = 1;
  localparam int LV_EEACC = 2;
  localparam int LV_OTP = 3;
  localparam int LV_PROG = 4;
  localparam int LV_XSEL_N = 5;
  localparam logic [5:0] LV_RST = 6'h21;
  localparam int PU_PWR = 0;
  localparam int PU_INIT = 1;
  localparam int PU_CONT = 2;
  localparam int PU_ONE = 3;
  localparam logic [1:0] BIDX_HDR = 2'h0;
  localparam logic [1:0] BIDX_OP = 2'h1;
  localparam logic [1:0] BIDX_ADR = 2'h2;
  localparam logic [1:0] BIDX_DAT = 2'h3;
  localparam logic [2:0] ICS_LAST_BIT = 3'h7;

  // ---------------------------------------------------------------------------
  // state types
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {ICS_IDLE, ICS_RX, ICS_ACK, ICS_TX, ICS_MACK} ics_st_t;

  typedef struct packed {
    logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p, mode_m, mode_s;
    ics_st_t st;
    logic [2:0] bitc;
    logic [7:0] sh;
    logic [1:0] bidx;
    logic [7:0] op;
    logic [7:0] addr;
    logic go_tx, fill, sda_oe, sda_o;
    logic [5:0] lvl;
    logic [3:0] tog;
  } ics_link_t;

  typedef struct packed {
    logic [5:0] lvl_m, lvl_s;
    logic [3:0] tog_m, tog_s, tog_p, pls;
  } ics_sys_t;

  // clock and data sync stages start at the idle pin level, so no false edge follows reset
  localparam ics_link_t ICS_LINK_RST = '{st: ICS_IDLE, lvl: LV_RST, scl_m: 1'b1, scl_s: 1'b1,
    scl_p: 1'b1, sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1, default: '0};
  localparam ics_sys_t ICS_SYS_RST = '{lvl_m: LV_RST, lvl_s: LV_RST, default: '0};

endpackage : ics_pkg

// ==== hw/ics_cmd_port.sv ====
`timescale 1ns/1ps
// Operation
// - lines idle high, device releases data
// - data bits sampled on clock rising edge
// - write header carries direction bit one
// - command bytes follow the four-wire opcode set
// - opcode 00 writes working RAM
// - opcode 40 reads working RAM
// - F0 power reset, C0 init reset
// - CC starts continuous measurement
// - CE starts one single conversion
// - 9E watchdog off, 9F watchdog on
// - A0 read, A1 write, A2/A4 erase
// - user EEPROM holds 128 bytes
// - EEPROM read returns filler then data
// - A1 then address then data byte
// - A2 clears addressed byte, data ignored
// - A4 clears whole EEPROM, ignores bytes
// - A6 reads, A7 writes OTP
// - external EEPROM uses four-wire opcodes
// - 50 read, 52 write, 53 select
// - two-wire mode only when mode pin high
module ics_cmd_port
  import ics_pkg::*;
#(
  parameter int RAM_AW = 8,
  parameter int EE_AW = 7,
  parameter int PM_AW = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_link,
  input wire logic mode_i2c,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic power_reset,
  output logic init_reset,
  output logic cont_cycle_go,
  output logic one_shot_conversion_go,
  output logic watchdog_en,
  output logic bandgap_on,
  output logic ee_access_en,
  output logic otp_en,
  output logic otp_prog_en,
  output logic ext_ee_sel_n
);

  // ---------------------------------------------------------------------------
  // link domain state and memories
  // ---------------------------------------------------------------------------
  ics_link_t q_q, q_d;
  logic [7:0] ram_mem [1<<RAM_AW];
  logic [7:0] ee_mem [1<<EE_AW];
  logic [7:0] pm_mem [1<<PM_AW];
  logic rise, fall, start, stop, done, ram_we, ee_we, ee_clr, pm_we;
  logic [7:0] rxb, rdat, ee_wd;

  // read opcodes switch the frame to transmit after the address
  function automatic logic ics_is_rd(input logic [7:0] op);
    ics_is_rd = (op == OP_RAM_RD) || (op == OP_EE_RD) || (op == OP_OTP_RD) || (op == OP_XEE_RD);
  endfunction : ics_is_rd

  // edge and condition detect on the second and third sync stages only
  assign rise = q_q.scl_s & ~q_q.scl_p;
  assign fall = ~q_q.scl_s & q_q.scl_p;
  assign start = q_q.scl_s & q_q.scl_p & q_q.sda_p & ~q_q.sda_s;
  assign stop = q_q.scl_s & q_q.scl_p & ~q_q.sda_p & q_q.sda_s;
  assign rxb = {q_q.sh[6:0], q_q.sda_s};
  assign done = (q_q.st == ICS_RX) && rise && (q_q.bitc == ICS_LAST_BIT);

  // read data mux, filler first on user EEPROM reads
  always_comb begin
    case (q_q.op)
      OP_RAM_RD: rdat = ram_mem[q_q.addr[RAM_AW-1:0]];
      OP_EE_RD: rdat = q_q.fill ? ICS_FILL : ee_mem[q_q.addr[EE_AW-1:0]];
      OP_OTP_RD, OP_XEE_RD: rdat = pm_mem[q_q.addr[PM_AW-1:0]];
      default: rdat = ICS_FILL;
    endcase
  end

  // protocol engine and command decoder
  always_comb begin
    q_d = q_q;
    ram_we = 1'b0;
    ee_we = 1'b0;
    ee_clr = 1'b0;
    pm_we = 1'b0;
    ee_wd = rxb;
    q_d.scl_m = scl_i;
    q_d.scl_s = q_q.scl_m;
    q_d.scl_p = q_q.scl_s;
    q_d.sda_m = sda_i;
    q_d.sda_s = q_q.sda_m;
    q_d.sda_p = q_q.sda_s;
    q_d.mode_m = mode_i2c;
    q_d.mode_s = q_q.mode_m;
    if (!q_q.mode_s) begin
      q_d.st = ICS_IDLE;
      q_d.sda_oe = 1'b0;
    end else if (start) begin
      q_d.st = ICS_RX;
      q_d.bitc = 3'h0;
      q_d.bidx = BIDX_HDR;
      q_d.sda_oe = 1'b0;
      q_d.go_tx = 1'b0;
    end else if (stop) begin
      q_d.st = ICS_IDLE;
      q_d.sda_oe = 1'b0;
      q_d.lvl[LV_XSEL_N] = 1'b1; // select ends with the frame
    end else begin
      unique case (q_q.st)
        ICS_IDLE: q_d.sda_oe = 1'b0;
        ICS_RX: begin
          if (rise) begin
            q_d.sh = rxb;
            q_d.bitc = q_q.bitc + 3'h1;
          end
          if (done) begin
            q_d.st = ICS_ACK;
            unique case (q_q.bidx)
              BIDX_HDR: begin
                // either direction accepted, opcode decides the data flow
                if (rxb[7:1] == ICS_DEV_ADDR) q_d.bidx = BIDX_OP;
                else q_d.st = ICS_IDLE;
              end
              BIDX_OP: begin
                q_d.op = rxb;
                case (rxb)
                  OP_PWR_RST: q_d.tog[PU_PWR] = ~q_q.tog[PU_PWR];
                  OP_INIT_RST: q_d.tog[PU_INIT] = ~q_q.tog[PU_INIT];
                  OP_CONT_GO: q_d.tog[PU_CONT] = ~q_q.tog[PU_CONT];
                  OP_ONE_GO: q_d.tog[PU_ONE] = ~q_q.tog[PU_ONE];
                  OP_WD_OFF: q_d.lvl[LV_WD] = 1'b0;
                  OP_WD_ON: q_d.lvl[LV_WD] = 1'b1;
                  OP_BGAP_OFF: q_d.lvl[LV_BGAP] = 1'b0;
                  OP_BGAP_ON: q_d.lvl[LV_BGAP] = 1'b1;
                  OP_EEACC_OFF: q_d.lvl[LV_EEACC] = 1'b0;
                  OP_EEACC_ON: q_d.lvl[LV_EEACC] = 1'b1;
                  OP_OTP_EN_OFF: q_d.lvl[LV_OTP] = 1'b0;
                  OP_OTP_EN_ON: q_d.lvl[LV_OTP] = 1'b1;
                  OP_PROG_OFF: q_d.lvl[LV_PROG] = 1'b0;
                  OP_PROG_ON: q_d.lvl[LV_PROG] = 1'b1;
                  OP_XEE_SEL: q_d.lvl[LV_XSEL_N] = 1'b0; // next byte is an opcode
                  OP_RAM_WR, OP_RAM_RD, OP_EE_RD, OP_EE_WR, OP_EE_ERASE, OP_EE_BERASE,
                  OP_OTP_RD, OP_OTP_WR, OP_XEE_RD, OP_XEE_WR: q_d.bidx = BIDX_ADR;
                  default: ; // unknown opcodes are acked and dropped
                endcase
              end
              BIDX_ADR: begin
                q_d.addr = rxb;
                q_d.bidx = BIDX_DAT;
                q_d.go_tx = ics_is_rd(q_q.op);
                q_d.fill = (q_q.op == OP_EE_RD);
              end
              BIDX_DAT: begin
                case (q_q.op)
                  OP_RAM_WR: begin
                    ram_we = 1'b1;
                    q_d.addr = q_q.addr + 8'h01;
                  end
                  OP_EE_WR: ee_we = 1'b1;
                  OP_EE_ERASE: begin
                    ee_we = 1'b1;
                    ee_wd = ICS_ERASED;
                  end
                  OP_EE_BERASE: ee_clr = 1'b1;
                  OP_OTP_WR: begin
                    pm_we = q_q.lvl[LV_OTP] & q_q.lvl[LV_PROG];
                    q_d.addr = q_q.addr + 8'h01;
                  end
                  OP_XEE_WR: begin
                    pm_we = 1'b1;
                    q_d.addr = q_q.addr + 8'h01;
                  end
                  default: ;
                endcase
              end
            endcase
          end
        end
        ICS_ACK: begin
          if (fall && !q_q.sda_oe) begin
            q_d.sda_oe = 1'b1;
          end else if (fall && q_q.go_tx) begin
            q_d.st = ICS_TX;
            q_d.sh = rdat;
            q_d.sda_oe = ~rdat[7];
            q_d.bitc = 3'h0;
          end else if (fall) begin
            q_d.sda_oe = 1'b0;
            q_d.st = ICS_RX;
          end
        end
        ICS_TX: begin
          // bits change on the falling edge so they stand at the master's rising edge
          if (rise) begin
            q_d.bitc = q_q.bitc + 3'h1;
          end else if (fall && q_q.bitc == 3'h0) begin
            q_d.sda_oe = 1'b0;
            q_d.st = ICS_MACK;
          end else if (fall) begin
            q_d.sda_oe = ~q_q.sh[ICS_LAST_BIT - q_q.bitc];
          end
        end
        ICS_MACK: begin
          if (rise && q_q.sda_s) begin
            q_d.st = ICS_IDLE; // master nack ends the read
          end else if (rise && q_q.fill) begin
            q_d.fill = 1'b0;
          end else if (rise) begin
            q_d.addr = q_q.addr + 8'h01;
          end else if (fall) begin
            q_d.st = ICS_TX;
            q_d.sh = rdat;
            q_d.sda_oe = ~rdat[7];
          end
        end
      endcase
    end
  end

  // link state register
  always_ff @(posedge clk_link or negedge rst_n) begin
    if (!rst_n) q_q <= ICS_LINK_RST;
    else q_q <= q_d;
  end

  // memory writes, no reset: contents are undefined until written
  always_ff @(posedge clk_link) begin
    if (ram_we) ram_mem[q_q.addr[RAM_AW-1:0]] <= rxb;
    if (pm_we) pm_mem[q_q.addr[PM_AW-1:0]] <= rxb;
    if (ee_clr) begin
      for (int i = 0; i < (1 << EE_AW); i++) ee_mem[i] <= ICS_ERASED;
    end else if (ee_we) begin
      ee_mem[q_q.addr[EE_AW-1:0]] <= ee_wd;
    end
  end

  // ---------------------------------------------------------------------------
  // system domain crossing
  // ---------------------------------------------------------------------------
  ics_sys_t s_q, s_d;
  // levels by two flops, commands by toggle; link clock is far slower than sys
  always_comb begin
    s_d = s_q;
    s_d.lvl_m = q_q.lvl;
    s_d.lvl_s = s_q.lvl_m;
    s_d.tog_m = q_q.tog;
    s_d.tog_s = s_q.tog_m;
    s_d.tog_p = s_q.tog_s;
    s_d.pls = s_q.tog_s ^ s_q.tog_p;
  end

  // system state register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) s_q <= ICS_SYS_RST;
    else s_q <= s_d;
  end

  assign sda_o = q_q.sda_o;
  assign sda_oe = q_q.sda_oe;
  assign power_reset = s_q.pls[PU_PWR];
  assign init_reset = s_q.pls[PU_INIT];
  assign cont_cycle_go = s_q.pls[PU_CONT];
  assign one_shot_conversion_go = s_q.pls[PU_ONE];
  assign watchdog_en = s_q.lvl_s[LV_WD];
  assign bandgap_on = s_q.lvl_s[LV_BGAP];
  assign ee_access_en = s_q.lvl_s[LV_EEACC];
  assign otp_en = s_q.lvl_s[LV_OTP];
  assign otp_prog_en = s_q.lvl_s[LV_PROG];
  assign ext_ee_sel_n = s_q.lvl_s[LV_XSEL_N];

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  sequence s_op_done(logic [7:0] opc);
    done && (q_q.bidx == BIDX_OP) && (rxb == opc) && q_q.mode_s && !start && !stop;
  endsequence
  sequence s_ack_slot;
    (q_q.st == ICS_ACK) && fall && !q_q.sda_oe && q_q.mode_s && !start && !stop;
  endsequence

  property p_idle_release;
    @(posedge clk_link) disable iff (!rst_n) (q_q.st == ICS_IDLE) |=> !q_q.sda_oe || (q_q.st != ICS_IDLE);
  endproperty
  a_idle_release: assert property (p_idle_release) else $error("data driven while idle");
  property p_hold_between_edges;
    @(posedge clk_link) disable iff (!rst_n)
      (q_q.st == ICS_RX && !rise && !done && q_q.mode_s && !start && !stop) |=> $stable(q_q.sh);
  endproperty
  a_hold_between_edges: assert property (p_hold_between_edges) else $error("bit taken off edge");
  property p_ack_drive;
    @(posedge clk_link) disable iff (!rst_n) s_ack_slot |=> q_q.sda_oe && (q_q.st == ICS_ACK);
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("byte not acknowledged");
  property p_ram_wr_op;
    @(posedge clk_link) disable iff (!rst_n) ram_we |-> (q_q.op == OP_RAM_WR) && (q_q.bidx == BIDX_DAT);
  endproperty
  a_ram_wr_op: assert property (p_ram_wr_op) else $error("ram write without opcode");
  property p_erase_zero;
    @(posedge clk_link) disable iff (!rst_n) (ee_we && q_q.op == OP_EE_ERASE) |-> (ee_wd == ICS_ERASED);
  endproperty
  a_erase_zero: assert property (p_erase_zero) else $error("erase wrote nonzero");
  property p_block_erase;
    @(posedge clk_link) disable iff (!rst_n) ee_clr |-> (q_q.op == OP_EE_BERASE) && !ee_we;
  endproperty
  a_block_erase: assert property (p_block_erase) else $error("block erase misdecoded");
  property p_filler_first;
    @(posedge clk_link) disable iff (!rst_n) (q_q.st == ICS_TX && q_q.fill) |-> (q_q.sh == ICS_FILL);
  endproperty
  a_filler_first: assert property (p_filler_first) else $error("filler byte not zero");
  property p_mode_off;
    @(posedge clk_link) disable iff (!rst_n) !q_q.mode_s |=> !q_q.sda_oe && (q_q.st == ICS_IDLE);
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("active outside two-wire mode");
  property p_cont_go;
    @(posedge clk_link) disable iff (!rst_n) s_op_done(OP_CONT_GO) |=> $changed(q_q.tog[PU_CONT]);
  endproperty
  a_cont_go: assert property (p_cont_go) else $error("continuous start lost");
  property p_wd_off;
    @(posedge clk_link) disable iff (!rst_n) s_op_done(OP_WD_OFF) |=> !q_q.lvl[LV_WD];
  endproperty
  a_wd_off: assert property (p_wd_off) else $error("watchdog not disabled");
  property p_one_pulse;
    @(posedge clk_sys) disable iff (!rst_n) one_shot_conversion_go |=> !one_shot_conversion_go;
  endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("single start longer than one cycle");

endmodule : ics_cmd_port

// ==== tb/ics_i2c_master.sv ====
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// two-wire bus master model
// -----------------------------------------------------------------------------
module ics_i2c_master (
  input wire logic clk_sys,
  input wire logic sda_w,
  output logic scl,
  output logic sda_m
);
  // phases in clk_sys cycles; keeps three link periods of setup and hold
  localparam int QTR = 100;
  localparam int HI = 130;

  // idle: both lines released to the pull-up
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end

  // every change lands on a falling edge of clk_sys
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick

  // data falls while the clock is high
  task automatic start();
    tick(QTR);
    sda_m = 1'b0;
    tick(HI);
    scl = 1'b0;
  endtask : start

  // data rises while the clock is high, bus then left idle
  task automatic stop();
    tick(QTR);
    sda_m = 1'b0;
    tick(QTR);
    scl = 1'b1;
    tick(HI);
    sda_m = 1'b1;
    tick(HI);
  endtask : stop

  // data only moves while the clock is low; sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    tick(QTR);
    sda_m = b;
    tick(QTR);
    scl = 1'b1;
    tick(HI / 2);
    r = sda_w;
    tick(HI - HI / 2);
    scl = 1'b0;
  endtask : bit_io

  // msb first, ninth clock reads the slave's acknowledge
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, ack);
  endtask : wbyte

  // released line while reading; nack ends the stream
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(nack, r);
  endtask : rbyte
endmodule : ics_i2c_master

// ==== tb/test_ics_cmd_port.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_ics_cmd_port;
  import ics_pkg::*;
  // -----------------------------------------------------------------------------
  // clocks, wires, instances
  // -----------------------------------------------------------------------------
  localparam logic [7:0] HW = 8'hC1;
  localparam logic [7:0] HR = 8'hC0;
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic rst_n = 1'b0;
  logic mode_i2c = 1'b1;
  logic scl, sda_m, sda_w, sda_o, sda_oe;
  logic power_reset, init_reset, cont_cycle_go, one_shot_conversion_go;
  logic watchdog_en, bandgap_on, ee_access_en, otp_en, otp_prog_en, ext_ee_sel_n;
  int failures = 0;
  int checks_done = 0;
  int n_pwr = 0;
  int n_init = 0;
  int n_cont = 0;
  int n_one = 0;
  logic [7:0] rd_q[$];

  always #2.5 clk_sys = ~clk_sys;
  // odd start offset keeps the link clock out of phase with clk_sys
  initial begin
    #1.3;
    forever #80 clk_link = ~clk_link;
  end
  // open drain with pull-up: low if anyone pulls
  assign sda_w = sda_oe ? (sda_o & sda_m) : sda_m;

  ics_cmd_port dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_link(clk_link),
    .mode_i2c(mode_i2c), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .power_reset(power_reset), .init_reset(init_reset), .cont_cycle_go(cont_cycle_go),
    .one_shot_conversion_go(one_shot_conversion_go), .watchdog_en(watchdog_en),
    .bandgap_on(bandgap_on), .ee_access_en(ee_access_en), .otp_en(otp_en),
    .otp_prog_en(otp_prog_en), .ext_ee_sel_n(ext_ee_sel_n));
  ics_i2c_master m (.clk_sys(clk_sys), .sda_w(sda_w), .scl(scl), .sda_m(sda_m));

  // pulse counters, one per command strobe; sampled away from the launching edge
  always @(negedge clk_sys) begin
    if (power_reset === 1'b1) n_pwr++;
    if (init_reset === 1'b1) n_init++;
    if (cont_cycle_go === 1'b1) n_cont++;
    if (one_shot_conversion_go === 1'b1) n_one++;
  end

  // -----------------------------------------------------------------------------
  // shared tasks
  // -----------------------------------------------------------------------------
  task automatic end_of_test();
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  // one framed transfer; every written byte must see the expected ack
  task automatic xfer(input logic [7:0] q[$], input int nrd, input logic ack_exp);
    logic a;
    logic [7:0] d;
    rd_q.delete();
    m.start();
    foreach (q[i]) begin
      m.wbyte(q[i], a);
      `CHK(a, ack_exp)
    end
    for (int i = 0; i < nrd; i++) begin
      m.rbyte(i == nrd - 1, d);
      rd_q.push_back(d);
    end
    m.stop();
  endtask : xfer

  // -----------------------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------------------
  task automatic t_reset();
    `CHK({watchdog_en, ext_ee_sel_n, bandgap_on, ee_access_en, otp_en, otp_prog_en}, 6'h30)
    `CHK({sda_oe, sda_o, power_reset, init_reset, cont_cycle_go, one_shot_conversion_go}, 6'h00)
  endtask : t_reset

  // ten single-byte opcodes chained in one frame, single conversion start twice
  task automatic t_cmds();
    xfer('{HW, OP_WD_OFF, OP_BGAP_ON, OP_EEACC_ON, OP_OTP_EN_ON, OP_PROG_ON, OP_PWR_RST,
      OP_INIT_RST, OP_CONT_GO, OP_ONE_GO, OP_ONE_GO}, 0, 1'b0);
    `CHK({watchdog_en, bandgap_on, ee_access_en, otp_en, otp_prog_en}, 5'h0F)
    `CHK({n_pwr, n_init, n_cont, n_one}, {32'd1, 32'd1, 32'd1, 32'd2})
  endtask : t_cmds

  // write across the top of the address space, read back the wrap
  task automatic t_ram();
    xfer('{HW, OP_RAM_WR, 8'hFF, 8'h5A, 8'hA5}, 0, 1'b0);
    xfer('{HR, OP_RAM_RD, 8'hFF}, 2, 1'b0);
    `CHK({rd_q[0], rd_q[1]}, 16'h5AA5)
  endtask : t_ram

  // last location, filler byte, single and block erase
  task automatic t_ee();
    xfer('{HW, OP_EE_WR, 8'h7F, 8'h3C}, 0, 1'b0);
    xfer('{HR, OP_EE_RD, 8'h7F}, 2, 1'b0);
    `CHK({rd_q[0], rd_q[1]}, 16'h003C)
    xfer('{HW, OP_EE_ERASE, 8'h7F, 8'h11}, 0, 1'b0);
    xfer('{HR, OP_EE_RD, 8'h7F}, 2, 1'b0);
    `CHK({rd_q[0], rd_q[1]}, 16'h0000)
    xfer('{HW, OP_EE_WR, 8'h7F, 8'h3C}, 0, 1'b0);
    xfer('{HW, OP_EE_BERASE, 8'h7F, 8'h3C}, 0, 1'b0);
    xfer('{HR, OP_EE_RD, 8'h7F}, 2, 1'b0);
    `CHK({rd_q[0], rd_q[1]}, 16'h0000)
  endtask : t_ee

  // programming refused without program enable, accepted with it
  task automatic t_otp();
    xfer('{HW, OP_XEE_WR, 8'h20, 8'h4E}, 0, 1'b0);
    xfer('{HW, OP_PROG_OFF, OP_OTP_WR, 8'h20, 8'h99}, 0, 1'b0);
    xfer('{HR, OP_OTP_RD, 8'h20}, 1, 1'b0);
    `CHK(rd_q[0], 8'h4E)
    xfer('{HW, OP_PROG_ON, OP_OTP_WR, 8'h20, 8'hC3}, 0, 1'b0);
    xfer('{HR, OP_XEE_RD, 8'h20}, 1, 1'b0);
    `CHK(rd_q[0], 8'hC3)
  endtask : t_otp

  // select held within the frame, dropped by the stop
  task automatic t_sel();
    logic a;
    m.start();
    m.wbyte(HW, a);
    m.wbyte(OP_XEE_SEL, a);
    m.tick(40);
    `CHK(ext_ee_sel_n, 1'b0)
    m.stop();
    `CHK(ext_ee_sel_n, 1'b1)
  endtask : t_sel

  // levels but program enable back to reset; wrong address and mode pin low are ignored
  task automatic t_off();
    xfer('{HW, OP_WD_ON, 8'h01, OP_BGAP_OFF, OP_EEACC_OFF, OP_OTP_EN_OFF}, 0, 1'b0);
    `CHK({watchdog_en, bandgap_on, ee_access_en, otp_en, otp_prog_en}, 5'h11)
    xfer('{8'hA1, OP_CONT_GO}, 0, 1'b1);
    @(negedge clk_sys);
    mode_i2c = 1'b0;
    m.tick(300);
    xfer('{HW, OP_CONT_GO}, 0, 1'b1);
    `CHK(n_cont, 1)
    mode_i2c = 1'b1;
  endtask : t_off

  // -----------------------------------------------------------------------------
  // main sequence and watchdog
  // -----------------------------------------------------------------------------
  initial begin
    repeat (3) @(negedge clk_sys);
    // link side only resets on its own edges, so hold until two have passed
    repeat (2) @(posedge clk_link);
    @(negedge clk_sys);
    t_reset();
    rst_n = 1'b1;
    m.tick(300);
    t_cmds();
    t_ram();
    t_ee();
    t_otp();
    t_sel();
    t_off();
    end_of_test();
  end

  // full run is about 1.3 ms of bus traffic
  initial begin
    #3000000;
    failures++;
    end_of_test();
  end
endmodule : test_ics_cmd_port
